/* verilog/sdram_cfg_defines.svh */
// offsets, field positions, masks, reset values and counts of the block
`ifndef SDRAM_CFG_DEFINES_SVH
`define SDRAM_CFG_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CONFIG        8'h00
`define OFS_ROW_TIMING    8'h04
`define OFS_SR_EXIT       8'h08
`define OFS_REFRESH       8'h0C

// ****************************************************************
// writable-bit masks, reserved bits are zero
// ****************************************************************
`define MASK_CONFIG       32'h80004F77
`define MASK_ROW_TIMING   32'hFF77FF70
`define MASK_SR_EXIT      32'h0000001F
`define MASK_REFRESH      32'h00001FFF

// ****************************************************************
// configuration field positions
// ****************************************************************
`define CFG_SR_BIT        31
`define CFG_NARROW_BIT    14
`define CFG_CL_HI         11
`define CFG_CL_LO         9
`define CFG_UNLOCK_BIT    8
`define CFG_BANK_HI       6
`define CFG_BANK_LO       4
`define CFG_PAGE_HI       2
`define CFG_PAGE_LO       0

// ****************************************************************
// reset values
// ****************************************************************
`define RST_CONFIG        32'h00000000
`define RST_ROW_TIMING    32'h00000000
`define RST_SR_EXIT       32'h00000000
`define RST_REFRESH       32'h00000000

// ****************************************************************
// init count in pclk cycles and base page column address bits
// ****************************************************************
`define INIT_CYCLES       16
`define PAGE_BASE_BITS    4'h8

`endif

/* verilog/sdram_cfg_pkg.sv */
// types shared by the sdram configuration and timing block
package sdram_cfg_pkg;

    // ************************************************************
    // register layouts
    // ************************************************************
    typedef struct packed {
        logic [4:0] refresh_cycle_time;
        logic [2:0] precharge_time;
        logic       rsvd23;
        logic [2:0] activate_to_access_time;
        logic       rsvd19;
        logic [2:0] write_recovery_time;
        logic [3:0] activate_to_precharge_time;
        logic [3:0] activate_to_activate_time;
        logic       rsvd7;
        logic [2:0] bank_to_bank_activate_time;
        logic [3:0] rsvd3_0;
    } row_timing_type;

    typedef struct packed {
        logic       narrow_bus_select;
        logic [2:0] cas_latency_field;
        logic [2:0] bank_count_field;
        logic [2:0] page_width_field;
    } mem_geometry_type;

    // ************************************************************
    // controller states, one-hot
    // ************************************************************
    typedef enum logic [4:0] {
        ST_UNINIT   = 5'b00001,
        ST_INIT     = 5'b00010,
        ST_READY    = 5'b00100,
        ST_SELF_REF = 5'b01000,
        ST_EXIT     = 5'b10000
    } ctrl_state_type;

endpackage

/* verilog/sdram_interval_timer.sv */
// down-counter that pulses once per programmed number of cycles
module sdram_interval_timer #(
    parameter int W = 13
) (
    input  wire logic         pclk,     // system clock
    input  wire logic         presetn,  // async reset, active low
    input  wire logic         load,     // restart with value
    input  wire logic         run,      // count this cycle
    input  wire logic [W-1:0] value,    // cycles per period
    output logic              expired   // one-cycle pulse
);

    logic [W-1:0] cnt_q;

    // a value of zero never expires, so an unset interval stays quiet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q   <= '0;
            expired <= 1'b0;
        end else if (load) begin
            cnt_q   <= value;
            expired <= 1'b0;
        end else if (run && cnt_q == W'(1)) begin
            cnt_q   <= value;
            expired <= 1'b1;
        end else begin
            expired <= 1'b0;
            if (run && cnt_q != '0) begin
                cnt_q <= cnt_q - W'(1);
            end
        end
    end

endmodule // sdram_interval_timer

/* verilog/sdram_config_timing.sv */
// sdram configuration registers, self-refresh and refresh sequencing
//
// Behaviour
// - once a lower-byte config write has started init, setting the self-refresh request enters self-refresh; clearing it leaves
// - config write on lower bytes starts init; upper-byte-only write does not
// - after the configuration write, sdram accesses are accepted
// - row-timing fields sit at their fixed bit positions
// - row-timing fields are memory clock cycles minus one
// - exit delay bits 4:0, plus one cycles, waited after self-refresh
// - refresh interval in cycles held in bits 12:0
// - configuration fields sit at their fixed bit positions
// - narrow-bus select 1 means a 16-bit sdram data bus
// - cas latency field 011b gives latency three
// - cas latency only updates when the same write sets the unlock bit
// - bank count field 010b means four banks
// - page width field 0 means 256-word pages
`include "sdram_cfg_defines.svh"

module sdram_config_timing #(
    parameter int ADDR_W      = 8,
    parameter int INIT_CYCLES = `INIT_CYCLES
) (
    input  wire logic              pclk,          // system clock
    input  wire logic              presetn,       // async reset, active low
    input  wire logic [ADDR_W-1:0] paddr,         // apb byte address
    input  wire logic              psel,          // apb select
    input  wire logic              penable,       // apb access phase
    input  wire logic              pwrite,        // apb direction
    input  wire logic [31:0]       pwdata,        // apb write data
    input  wire logic [3:0]        pstrb,         // apb byte strobes
    output logic [31:0]            prdata,        // apb read data
    output logic                   pready,        // apb ready
    output logic                   pslverr,       // unmapped address
    output logic                   mem_access_en, // sdram accesses allowed
    output logic                   sdram_cke,     // clock enable to sdram
    output logic                   sr_active,     // sdram in self-refresh
    output logic                   init_start,    // init sequence pulse
    output logic                   refresh_req,   // auto refresh pulse
    output sdram_cfg_pkg::row_timing_type   row_timing, // timing fields
    output sdram_cfg_pkg::mem_geometry_type geometry,   // geometry fields
    output logic [3:0]             bank_count,    // number of banks
    output logic [3:0]             page_col_bits, // column address bits
    output logic [4:0]             sr_exit_delay  // exit delay field
);
    import sdram_cfg_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************
    // byte-lane merge, reserved bits forced to zero
    function automatic logic [31:0] merge_lanes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  strb,
        input logic [31:0] mask
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    // ************************************************************
    // apb slave
    // ************************************************************
    logic [31:0]    config_q;
    logic [31:0]    row_timing_q;
    logic [31:0]    sr_exit_q;
    logic [31:0]    refresh_q;
    ctrl_state_type state_q;
    ctrl_state_type state_d;
    logic           wr_en;
    logic           wr_cfg_lo;
    logic           wr_cfg_hi;
    logic           addr_ok;
    logic [31:0]    rd_mux;

    // ready rises in the access phase, giving one fixed wait-free answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // address decode and read mux
    always_comb begin
        addr_ok = 1'b1;
        rd_mux  = 32'h00000000;
        unique case (paddr)
            `OFS_CONFIG:     rd_mux = config_q;
            `OFS_ROW_TIMING: rd_mux = row_timing_q;
            `OFS_SR_EXIT:    rd_mux = sr_exit_q;
            `OFS_REFRESH:    rd_mux = refresh_q;
            default:         addr_ok = 1'b0;
        endcase
    end

    assign wr_en     = psel && penable && pready && pwrite && addr_ok;
    assign wr_cfg_lo = wr_en && paddr == `OFS_CONFIG && |pstrb[2:0];
    assign wr_cfg_hi = wr_en && paddr == `OFS_CONFIG && pstrb[3];

    // ************************************************************
    // register file
    // ************************************************************
    // timing registers, reserved bits masked on write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_timing_q <= `RST_ROW_TIMING;
            sr_exit_q    <= `RST_SR_EXIT;
            refresh_q    <= `RST_REFRESH;
        end else if (wr_en) begin
            if (paddr == `OFS_ROW_TIMING) begin
                row_timing_q <= merge_lanes(row_timing_q, pwdata, pstrb,
                                            `MASK_ROW_TIMING);
            end
            if (paddr == `OFS_SR_EXIT) begin
                sr_exit_q <= merge_lanes(sr_exit_q, pwdata, pstrb,
                                         `MASK_SR_EXIT);
            end
            if (paddr == `OFS_REFRESH) begin
                refresh_q <= merge_lanes(refresh_q, pwdata, pstrb,
                                         `MASK_REFRESH);
            end
        end
    end

    // configuration; cas latency is locked unless unlock is written as 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_q <= `RST_CONFIG;
        end else if (wr_en && paddr == `OFS_CONFIG) begin
            config_q <= merge_lanes(config_q, pwdata, pstrb, `MASK_CONFIG);
            if (!(pstrb[1] && pwdata[`CFG_UNLOCK_BIT])) begin
                config_q[`CFG_CL_HI:`CFG_CL_LO] <=
                    config_q[`CFG_CL_HI:`CFG_CL_LO];
            end
        end
    end

    // ************************************************************
    // derived configuration outputs
    // ************************************************************
    // fields pass through as cycles minus one; the sequencer adds one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_timing    <= '0;
            sr_exit_delay <= 5'h00;
            geometry      <= '0;
            bank_count    <= 4'h1;
            page_col_bits <= `PAGE_BASE_BITS;
        end else begin
            row_timing    <= row_timing_type'(row_timing_q);
            sr_exit_delay <= sr_exit_q[4:0];
            geometry.narrow_bus_select <= config_q[`CFG_NARROW_BIT];
            geometry.cas_latency_field <=
                config_q[`CFG_CL_HI:`CFG_CL_LO];
            geometry.bank_count_field  <=
                config_q[`CFG_BANK_HI:`CFG_BANK_LO];
            geometry.page_width_field  <=
                config_q[`CFG_PAGE_HI:`CFG_PAGE_LO];
            // 0,1,2,3 give 1,2,4,8 banks; larger codes wrap on low bits
            bank_count <= 4'h1 << config_q[5:4];
            // 256-word page at code 0, doubling per step
            page_col_bits <= `PAGE_BASE_BITS +
                             {2'b00, config_q[1:0]};
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    localparam int INIT_W = $clog2(INIT_CYCLES + 1);
    logic [INIT_W-1:0] init_cnt_q;
    logic              sr_req;
    logic              exit_done;
    logic              refresh_pulse;

    assign sr_req = config_q[`CFG_SR_BIT];

    // init timer, restarted by every lower-byte configuration write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_cnt_q <= '0;
        end else if (wr_cfg_lo) begin
            init_cnt_q <= INIT_W'(INIT_CYCLES - 1);
        end else if (state_q == ST_INIT && init_cnt_q != '0) begin
            init_cnt_q <= init_cnt_q - INIT_W'(1);
        end
    end

    // next state; a new lower-byte write always restarts init
    always_comb begin
        state_d = state_q;
        if (wr_cfg_lo) begin
            state_d = ST_INIT;
        end else begin
            unique case (state_q)
                ST_UNINIT:   state_d = ST_UNINIT;
                ST_INIT: begin
                    if (init_cnt_q == '0) begin
                        state_d = sr_req ? ST_SELF_REF : ST_READY;
                    end
                end
                ST_READY: begin
                    if (sr_req) begin
                        state_d = ST_SELF_REF;
                    end
                end
                ST_SELF_REF: begin
                    if (!sr_req) begin
                        state_d = ST_EXIT;
                    end
                end
                ST_EXIT: begin
                    if (exit_done) begin
                        state_d = sr_req ? ST_SELF_REF : ST_READY;
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_UNINIT;
        end else begin
            state_q <= state_d;
        end
    end

    // pin-facing status follows the next state to save a cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_access_en <= 1'b0;
            sdram_cke     <= 1'b1;
            sr_active     <= 1'b0;
            init_start    <= 1'b0;
            refresh_req   <= 1'b0;
        end else begin
            mem_access_en <= state_d == ST_READY;
            sdram_cke     <= state_d != ST_SELF_REF;
            sr_active     <= state_d == ST_SELF_REF;
            init_start    <= wr_cfg_lo;
            // gate on next state so no refresh lands as cke drops
            refresh_req   <= refresh_pulse && state_d == ST_READY;
        end
    end

    // exit delay: field plus one cycles from entering the exit state
    sdram_interval_timer #(.W(6)) u_exit_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (state_q != ST_EXIT),
        .run     (state_q == ST_EXIT),
        .value   ({1'b0, sr_exit_q[4:0]} + 6'h01),
        .expired (exit_done)
    );

    // refresh interval; held in reload outside ready so each entry is fresh
    sdram_interval_timer #(.W(13)) u_refresh_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (state_q != ST_READY),
        .run     (state_q == ST_READY),
        .value   (refresh_q[12:0]),
        .expired (refresh_pulse)
    );

    // ************************************************************
    // assertions
    // ************************************************************
    logic [5:0]  exit_len_q;
    logic [13:0] rf_gap_q;
    logic        rf_gap_ok_q;

    // cycles spent in the exit state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exit_len_q <= 6'h00;
        end else begin
            exit_len_q <= (state_q == ST_EXIT) ? exit_len_q + 6'h01 : 6'h00;
        end
    end

    // cycles between two refresh pulses in an unbroken ready spell
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rf_gap_q    <= 14'h0000;
            rf_gap_ok_q <= 1'b0;
        end else if (state_q != ST_READY ||
                     (wr_en && paddr == `OFS_REFRESH)) begin
            rf_gap_q    <= 14'h0000;
            rf_gap_ok_q <= 1'b0;
        end else if (refresh_pulse) begin
            rf_gap_q    <= 14'h0001;
            rf_gap_ok_q <= 1'b1;
        end else begin
            rf_gap_q <= rf_gap_q + 14'h0001;
        end
    end

    sequence s_sr_set_in_ready;
        state_q == ST_READY && wr_cfg_hi && !wr_cfg_lo &&
            pwdata[`CFG_SR_BIT];
    endsequence

    sequence s_cke_low_held;
        (!sdram_cke && sr_active) [*2];
    endsequence

    property p_sr_enter;
        @(posedge pclk) disable iff (!presetn)
        s_sr_set_in_ready |-> ##2 s_cke_low_held;
    endproperty
    a_sr_enter: assert property (p_sr_enter)
        else $error("self-refresh not entered after request");

    property p_exit_wait;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_EXIT && state_d == ST_READY) |->
            exit_len_q == {1'b0, sr_exit_q[4:0]} + 6'h01;
    endproperty
    a_exit_wait: assert property (p_exit_wait)
        else $error("exit delay length wrong");

    property p_hi_no_init;
        @(posedge pclk) disable iff (!presetn)
        (wr_cfg_hi && !wr_cfg_lo && state_q != ST_INIT) |=>
            !init_start && state_q != ST_INIT;
    endproperty
    a_hi_no_init: assert property (p_hi_no_init)
        else $error("upper-byte write started init");

    property p_lo_init;
        @(posedge pclk) disable iff (!presetn)
        wr_cfg_lo |=> init_start && state_q == ST_INIT ##1 !init_start;
    endproperty
    a_lo_init: assert property (p_lo_init)
        else $error("lower-byte write did not start init");

    property p_cl_lock;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `OFS_CONFIG && !pwdata[`CFG_UNLOCK_BIT]) |=>
            $stable(config_q[`CFG_CL_HI:`CFG_CL_LO]);
    endproperty
    a_cl_lock: assert property (p_cl_lock)
        else $error("cas latency changed without unlock");

    property p_ready_after_init;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_INIT && init_cnt_q == '0 && !sr_req && !wr_cfg_lo)
            |=> mem_access_en && state_q == ST_READY;
    endproperty
    a_ready_after_init: assert property (p_ready_after_init)
        else $error("accesses not enabled after init");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == `OFS_ROW_TIMING) |=>
            (prdata & ~`MASK_ROW_TIMING) == 32'h00000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved timing bits read nonzero");

    property p_refresh_gap;
        @(posedge pclk) disable iff (!presetn)
        (refresh_pulse && rf_gap_ok_q && state_q == ST_READY) |->
            rf_gap_q == {1'b0, refresh_q[12:0]};
    endproperty
    a_refresh_gap: assert property (p_refresh_gap)
        else $error("refresh interval wrong");

    property p_bank_four;
        @(posedge pclk) disable iff (!presetn)
        config_q[`CFG_BANK_HI:`CFG_BANK_LO] == 3'h2 |=> bank_count == 4'h4;
    endproperty
    a_bank_four: assert property (p_bank_four)
        else $error("bank count not four");

    property p_page_256;
        @(posedge pclk) disable iff (!presetn)
        config_q[`CFG_PAGE_HI:`CFG_PAGE_LO] == 3'h0 |=> page_col_bits == 4'h8;
    endproperty
    a_page_256: assert property (p_page_256)
        else $error("page width not 256 words");

endmodule // sdram_config_timing

/* verification/sdram_model.sv */
// behavioural sdram partner: watches clock enable and refresh commands
module sdram_model (
    input  wire logic pclk,        // memory side clock
    input  wire logic cke,         // clock enable from controller
    input  wire logic refresh_req, // auto refresh command
    output int        gap,         // cycles between last two refreshes
    output int        bad_ref      // refreshes seen while asleep
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;

    // a refresh while cke is low would break self-refresh
    always @(posedge pclk) begin
        cnt <= cnt + 1;
        if (refresh_req === 1'b1) begin
            gap <= cnt + 1;
            cnt <= 0;
            if (cke !== 1'b1)
                bad_ref <= bad_ref + 1;
        end
    end
endmodule // sdram_model

/* verification/tb_sdram_config_timing.sv */
// self-checking bench for the sdram configuration and timing block
`include "sdram_cfg_defines.svh"
module tb_sdram_config_timing;
    import sdram_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int INIT_N = 2; // short init keeps the run brief
    logic             pclk, presetn, psel, penable, pwrite;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, rd;
    logic [3:0]       pstrb, bank_count, page_col_bits;
    logic             pready, pslverr, err, mem_access_en, sdram_cke;
    logic             sr_active, init_start, refresh_req;
    logic [4:0]       sr_exit_delay;
    row_timing_type   row_timing;
    mem_geometry_type geometry;
    int               num_errors = 0, checked = 0, n_init = 0;
    int               gap, bad_ref, n;

    sdram_config_timing #(.INIT_CYCLES(INIT_N)) sdram_config_timing_inst (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .mem_access_en, .sdram_cke, .sr_active,
        .init_start, .refresh_req, .row_timing, .geometry, .bank_count,
        .page_col_bits, .sr_exit_delay);
    sdram_model sdram_model_inst (
        .pclk, .cke(sdram_cke), .refresh_req, .gap, .bad_ref);

    // init pulses counted here, not trusted from state
    always @(posedge pclk)
        if (init_start === 1'b1)
            n_init++;

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20) begin
            num_errors++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_ready(output int k);
        for (k = 1; k <= 60; k++) begin
            @(posedge pclk);
            if (mem_access_en === 1'b1)
                break;
        end
        if (k > 60) begin
            num_errors++;
            wrap_up();
        end
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, 8'(4 * k), 32'h0, 4'h0);
            check(rd, 32'h0);
        end
        check({sdram_cke, bank_count, page_col_bits}, 9'h118);
        $display("test reset done");
    endtask

    task automatic t_sequence();
        apb(1'b1, `OFS_ROW_TIMING, 32'h61114610, 4'hF);
        apb(1'b1, `OFS_SR_EXIT, 32'hFFFFFFFF, 4'hF);
        apb(1'b0, `OFS_SR_EXIT, 32'h0, 4'h0);
        check(rd, 32'h1F);
        apb(1'b1, `OFS_SR_EXIT, 32'h6, 4'hF);
        apb(1'b1, `OFS_REFRESH, 32'h61A, 4'hF);
        apb(1'b1, `OFS_CONFIG, 32'h4720, 4'hF);
        wait_ready(n);
        check(n_init, 1);
        check(mem_access_en, 1'b1);
        check(row_timing, 32'h61114610);
        check(sr_exit_delay, 5'h6);
        check(geometry, 10'h2D0);
        check({bank_count, page_col_bits}, 8'h48);
        apb(1'b0, `OFS_CONFIG, 32'h0, 4'h0);
        check(rd, 32'h4720);
        check(err, 1'b0);
        $display("test sequence done");
    endtask

    // locked latency and a short refresh interval, reloaded by re-init
    task automatic t_relock();
        apb(1'b1, `OFS_REFRESH, 32'hFFFF0010, 4'hF);
        apb(1'b0, `OFS_REFRESH, 32'h0, 4'h0);
        check(rd, 32'h10);
        apb(1'b1, `OFS_CONFIG, 32'h4A20, 4'hF);
        wait_ready(n);
        check(n_init, 2);
        check(geometry.cas_latency_field, 3'b011);
        repeat (60) @(posedge pclk);
        check(gap, 16);
        $display("test relock done");
    endtask

    task automatic t_self_refresh();
        apb(1'b1, `OFS_CONFIG, 32'h80000000, 4'h8);
        repeat (2) @(posedge pclk);
        check({sdram_cke, sr_active}, 2'b01);
        repeat (40) @(posedge pclk);
        check(n_init, 2);
        check(bad_ref, 0);
        apb(1'b1, `OFS_CONFIG, 32'h0, 4'h8);
        wait_ready(n);
        check(n >= 7, 1'b1);
        check({sdram_cke, sr_active}, 2'b10);
        apb(1'b0, `OFS_CONFIG, 32'h0, 4'h0);
        check(rd, 32'h4620);
        $display("test self refresh done");
    endtask

    task automatic t_unmapped();
        apb(1'b1, 8'h10, 32'hFFFFFFFF, 4'hF);
        check(err, 1'b1);
        apb(1'b0, 8'h10, 32'h0, 4'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        $display("test unmapped done");
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_sequence();
        t_relock();
        t_self_refresh();
        t_unmapped();
        wrap_up();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        wrap_up();
    end
endmodule // tb_sdram_config_timing
